/* File: rtl/feature_page_pkg.sv */
// shared constants for the general settings feature page
package feature_page_pkg;

   // register word indices; byte address is four times the index
   localparam logic [5:0]  IDX_RESERVED  = 6'h30;
   localparam logic [5:0]  IDX_TRIG_CFG  = 6'h32;
   localparam logic [5:0]  IDX_GEN_AXIS  = 6'h34;
   localparam logic [5:0]  IDX_GAIN_X    = 6'h36;
   localparam logic [5:0]  IDX_GAIN_Y    = 6'h38;
   localparam logic [5:0]  IDX_GAIN_Z    = 6'h3A;
   localparam logic [5:0]  IDX_MOTION    = 6'h3C;

   // field positions inside the general axis settings word
   localparam int          POS_MAP_X     = 0;
   localparam int          POS_SIGN_X    = 2;
   localparam int          POS_MAP_Y     = 3;
   localparam int          POS_SIGN_Y    = 5;
   localparam int          POS_MAP_Z     = 6;
   localparam int          POS_SIGN_Z    = 8;
   localparam int          POS_SELF_OFF  = 9;
   localparam int          POS_NVM_PREP  = 10;
   // gain enable position inside the third gain word
   localparam int          POS_GAIN_EN   = 11;

   // axis source codes
   localparam logic [1:0]  SRC_X         = 2'h0;
   localparam logic [1:0]  SRC_Y         = 2'h1;
   localparam logic [1:0]  SRC_Z         = 2'h2;
   localparam logic [1:0]  SRC_RSVD      = 2'h3;

   // values after reset
   localparam logic [7:0]  RST_BURST_LEN = 8'h00;
   localparam logic [15:0] RST_GEN_AXIS  = 16'h0088;
   localparam logic [10:0] RST_RATIO     = 11'h000;
   localparam logic [15:0] RST_MOTION    = 16'hE005;

   // legal gain ratio window, unsigned one integer and ten fraction bits
   localparam logic [10:0] RATIO_MIN     = 11'h300;
   localparam logic [10:0] RATIO_MAX     = 11'h500;

   // bus answer codes
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

/* File: rtl/axis_remap.sv */
// one output axis: source select with reserved fallback and sign inversion
`timescale 1ns/10ps
module axis_remap
   import feature_page_pkg::*;
#(
   parameter logic [1:0] FALLBACK = SRC_X
) (
   // raw axis samples
   input  wire logic [15:0] src_x,
   input  wire logic [15:0] src_y,
   input  wire logic [15:0] src_z,
   // controls
   input  wire logic [1:0]  sel,
   input  wire logic        invert,
   // result
   output logic      [15:0] axis_out
);

   logic [1:0]  eff_sel;
   logic [15:0] picked;

   // reserved code falls back to this axis' own source
   always_comb begin
      eff_sel = (sel == SRC_RSVD) ? FALLBACK : sel;
      unique case (eff_sel)
         SRC_Y:   picked = src_y;
         SRC_Z:   picked = src_z;
         default: picked = src_x;
      endcase
      // most negative value saturates, plain negation would wrap to itself
      if (!invert) begin
         axis_out = picked;
      end else if (picked == 16'h8000) begin
         axis_out = 16'h7FFF;
      end else begin
         axis_out = 16'(-picked);
      end
   end

endmodule

/* File: rtl/feature_page_regs.sv */
// general settings feature page behind an axi4-lite slave
`timescale 1ns/10ps
// Overview of operation
// - burst length caps words per download burst
// - first axis source select, reserved gives x
// - second axis select, reserved y, reset y
// - third axis select, reserved z, reset z
// - sign bit set negates that axis
// - self offset bit hands offsets to device
// - bit ten prepares non-volatile memory programming
// - eleven-bit gain ratios valid 0.75 to 1.25
// - device clears gain enable when update completes
module feature_page_regs
   import feature_page_pkg::*;
(
   // clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // axi4-lite write address and data
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // raw gyroscope samples
   input  wire logic [15:0] raw_x,
   input  wire logic [15:0] raw_y,
   input  wire logic [15:0] raw_z,
   // remapped samples
   output logic [15:0]      axis_first,
   output logic [15:0]      axis_second,
   output logic [15:0]      axis_third,
   // configuration stream download
   input  wire logic        stream_word,
   output logic [7:0]       burst_len,
   output logic             burst_end,
   // offset and memory control
   input  wire logic        host_offset_wr,
   output logic             offset_wr_apply,
   output logic             offset_auto,
   output logic             nvm_prepared,
   // gain update engine
   output logic [10:0]      gain_ratio_x,
   output logic [10:0]      gain_ratio_y,
   output logic [10:0]      gain_ratio_z,
   output logic             gain_ratio_ok,
   output logic             gain_start,
   input  wire logic        gain_done
);

   typedef enum logic [1:0] {
      GAIN_IDLE = 2'b01,
      GAIN_BUSY = 2'b10
   } gain_state_e;

   typedef struct packed {
      logic [7:0]  burst_len;
      logic [7:0]  burst_cnt;
      logic        burst_end;
      logic [15:0] gen_axis;
      logic [10:0] ratio_x;
      logic [10:0] ratio_y;
      logic [10:0] ratio_z;
      logic        ratio_ok;
      logic        gain_en;
      gain_state_e gain_st;
      logic [15:0] motion;
      logic [15:0] ax1;
      logic [15:0] ax2;
      logic [15:0] ax3;
      logic        aw_got;
      logic [5:0]  aw_idx;
      logic        w_got;
      logic [15:0] wdata;
      logic [1:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } state_s;

   state_s q;
   state_s d;

   logic [15:0] rm1;
   logic [15:0] rm2;
   logic [15:0] rm3;
   logic        aw_hs;
   logic        w_hs;
   logic        ar_hs;
   logic        wr_fire;
   logic [5:0]  ar_idx;

   // merge the two low byte lanes into a sixteen-bit word
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [1:0] strb);
      merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
   endfunction

   // ratio inside the legal window
   function automatic logic ratio_in(input logic [10:0] r);
      ratio_in = (r >= RATIO_MIN) && (r <= RATIO_MAX);
   endfunction

   // word index and whether it is mapped
   function automatic logic mapped(input logic [5:0] idx);
      mapped = (idx == IDX_RESERVED) || (idx == IDX_TRIG_CFG) || (idx == IDX_GEN_AXIS) ||
               (idx == IDX_GAIN_X) || (idx == IDX_GAIN_Y) || (idx == IDX_GAIN_Z) ||
               (idx == IDX_MOTION);
   endfunction

   // remap datapaths, each with its own reserved fallback
   axis_remap #(.FALLBACK(SRC_X)) u_map1 (
      .src_x    (raw_x),
      .src_y    (raw_y),
      .src_z    (raw_z),
      .sel      (q.gen_axis[POS_MAP_X +: 2]),
      .invert   (q.gen_axis[POS_SIGN_X]),
      .axis_out (rm1)
   );
   axis_remap #(.FALLBACK(SRC_Y)) u_map2 (
      .src_x    (raw_x),
      .src_y    (raw_y),
      .src_z    (raw_z),
      .sel      (q.gen_axis[POS_MAP_Y +: 2]),
      .invert   (q.gen_axis[POS_SIGN_Y]),
      .axis_out (rm2)
   );
   axis_remap #(.FALLBACK(SRC_Z)) u_map3 (
      .src_x    (raw_x),
      .src_y    (raw_y),
      .src_z    (raw_z),
      .sel      (q.gen_axis[POS_MAP_Z +: 2]),
      .invert   (q.gen_axis[POS_SIGN_Z]),
      .axis_out (rm3)
   );

   // handshakes; readies drop while frozen so nothing is taken unseen
   assign s_axi_awready = ce && !q.aw_got && !q.bvalid;
   assign s_axi_wready  = ce && !q.w_got && !q.bvalid;
   assign s_axi_arready = ce && !q.rvalid;
   assign aw_hs         = s_axi_awvalid && s_axi_awready;
   assign w_hs          = s_axi_wvalid && s_axi_wready;
   assign ar_hs         = s_axi_arvalid && s_axi_arready;
   assign wr_fire       = q.aw_got && q.w_got && !q.bvalid;
   assign ar_idx        = s_axi_araddr[7:2];

   // next state
   always_comb begin
      d = q;
      d.burst_end = 1'b0;
      d.ax1 = rm1;
      d.ax2 = rm2;
      d.ax3 = rm3;
      d.ratio_ok = ratio_in(q.ratio_x) && ratio_in(q.ratio_y) && ratio_in(q.ratio_z);
      // count words, close burst at limit
      if (stream_word) begin
         if ((q.burst_len == 8'h00) || (q.burst_cnt == 8'(q.burst_len - 8'h01))) begin
            d.burst_cnt = 8'h00;
            d.burst_end = 1'b1;
         end else begin
            d.burst_cnt = 8'(q.burst_cnt + 8'h01);
         end
      end
      // capture address and data in either order
      if (aw_hs) begin
         d.aw_got = 1'b1;
         d.aw_idx = s_axi_awaddr[7:2];
      end
      if (w_hs) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata[15:0];
         d.wstrb = s_axi_wstrb[1:0];
      end
      // completion clears enable, a same-cycle write below wins
      unique case (q.gain_st)
         GAIN_IDLE: begin
            if (q.gain_en) begin
               d.gain_st = GAIN_BUSY;
            end
         end
         GAIN_BUSY: begin
            if (gain_done) begin
               d.gain_en = 1'b0;
               d.gain_st = GAIN_IDLE;
            end
         end
         default: d.gain_st = GAIN_IDLE;
      endcase
      if (wr_fire) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = mapped(q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
         unique case (q.aw_idx)
            IDX_TRIG_CFG: d.burst_len = 8'(merge16({8'h00, q.burst_len}, q.wdata, q.wstrb));
            IDX_GEN_AXIS: d.gen_axis  = merge16(q.gen_axis, q.wdata, q.wstrb) & 16'h07FF;
            IDX_GAIN_X:   d.ratio_x   = 11'(merge16({5'h00, q.ratio_x}, q.wdata, q.wstrb));
            IDX_GAIN_Y:   d.ratio_y   = 11'(merge16({5'h00, q.ratio_y}, q.wdata, q.wstrb));
            IDX_GAIN_Z: begin
               d.ratio_z = 11'(merge16({5'h00, q.ratio_z}, q.wdata, q.wstrb));
               if (q.wstrb[1]) begin
                  d.gain_en = q.wdata[POS_GAIN_EN] | (d.gain_en & ~gain_done);
               end
            end
            IDX_MOTION:   d.motion    = merge16(q.motion, q.wdata, q.wstrb);
            default:      d.bresp     = d.bresp;
         endcase
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      // read answers one edge after the address is taken
      if (ar_hs) begin
         d.rvalid = 1'b1;
         d.rresp  = mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
         unique case (ar_idx)
            IDX_TRIG_CFG: d.rdata = {24'h000000, q.burst_len};
            IDX_GEN_AXIS: d.rdata = {16'h0000, q.gen_axis};
            IDX_GAIN_X:   d.rdata = {21'h000000, q.ratio_x};
            IDX_GAIN_Y:   d.rdata = {21'h000000, q.ratio_y};
            IDX_GAIN_Z:   d.rdata = {20'h00000, q.gain_en, q.ratio_z};
            IDX_MOTION:   d.rdata = {16'h0000, q.motion};
            default:      d.rdata = 32'h00000000;
         endcase
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '{burst_len: RST_BURST_LEN, burst_cnt: 8'h00, burst_end: 1'b0,
                gen_axis: RST_GEN_AXIS, ratio_x: RST_RATIO, ratio_y: RST_RATIO,
                ratio_z: RST_RATIO, ratio_ok: 1'b0, gain_en: 1'b0, gain_st: GAIN_IDLE,
                motion: RST_MOTION, ax1: 16'h0000, ax2: 16'h0000, ax3: 16'h0000,
                aw_got: 1'b0, aw_idx: 6'h00, w_got: 1'b0, wdata: 16'h0000,
                wstrb: 2'h0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
                rdata: 32'h00000000, rresp: RESP_OKAY};
      end else if (ce) begin
         q <= d;
      end
   end

   // outputs
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign axis_first    = q.ax1;
   assign axis_second   = q.ax2;
   assign axis_third    = q.ax3;
   assign burst_len     = q.burst_len;
   assign burst_end     = q.burst_end;
   assign offset_auto   = q.gen_axis[POS_SELF_OFF];
   // host offset writes pass only with correction off
   assign offset_wr_apply = host_offset_wr && !q.gen_axis[POS_SELF_OFF];
   assign nvm_prepared  = q.gen_axis[POS_NVM_PREP];
   assign gain_ratio_x  = q.ratio_x;
   assign gain_ratio_y  = q.ratio_y;
   assign gain_ratio_z  = q.ratio_z;
   assign gain_ratio_ok = q.ratio_ok;
   // start pulse is the idle-to-busy step, one cycle
   assign gain_start    = ce && (q.gain_st == GAIN_IDLE) && q.gain_en;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_gen_write;
      ce && wr_fire && (q.aw_idx == IDX_GEN_AXIS) && (q.wstrb == 2'h3);
   endsequence
   sequence s_done_no_set;
      ce && (q.gain_st == GAIN_BUSY) && gain_done && !(wr_fire && q.aw_idx == IDX_GAIN_Z);
   endsequence

   property p_burst_wrap;
      ce && stream_word && (q.burst_len != 8'h00) && (q.burst_cnt == 8'(q.burst_len - 8'h01))
         |=> burst_end && (q.burst_cnt == 8'h00);
   endproperty
   a_burst_wrap: assert property (p_burst_wrap) else $error("burst did not close");

   property p_first_fallback;
      ce && (q.gen_axis[1:0] == SRC_RSVD) && !q.gen_axis[POS_SIGN_X] ##0 $stable(q.gen_axis)
         |=> axis_first == $past(raw_x);
   endproperty
   a_first_fallback: assert property (p_first_fallback) else $error("first axis fallback");

   property p_second_fallback;
      ce && (q.gen_axis[4:3] == SRC_RSVD) && !q.gen_axis[POS_SIGN_Y]
         |=> axis_second == $past(raw_y);
   endproperty
   a_second_fallback: assert property (p_second_fallback) else $error("second axis fallback");

   property p_third_fallback;
      ce && (q.gen_axis[7:6] == SRC_RSVD) && !q.gen_axis[POS_SIGN_Z]
         |=> axis_third == $past(raw_z);
   endproperty
   a_third_fallback: assert property (p_third_fallback) else $error("third axis fallback");

   property p_sign_negates;
      ce && (q.gen_axis[2:0] == 3'b100) && (raw_x != 16'h8000)
         |=> axis_first == 16'(-$past(raw_x));
   endproperty
   a_sign_negates: assert property (p_sign_negates) else $error("sign inversion wrong");

   property p_offset_gate;
      host_offset_wr |-> (offset_wr_apply == !offset_auto);
   endproperty
   a_offset_gate: assert property (p_offset_gate) else $error("offset write gating");

   property p_nvm_follow;
      s_gen_write |=> nvm_prepared == $past(q.wdata[POS_NVM_PREP]);
   endproperty
   a_nvm_follow: assert property (p_nvm_follow) else $error("memory prep bit lost");

   property p_ratio_range;
      ce && !ratio_in(q.ratio_x) |=> !gain_ratio_ok;
   endproperty
   a_ratio_range: assert property (p_ratio_range) else $error("ratio flag wrong");

   property p_gain_clear;
      s_done_no_set |=> !q.gain_en ##0 (q.gain_st == GAIN_IDLE);
   endproperty
   a_gain_clear: assert property (p_gain_clear) else $error("gain enable not cleared");

   property p_reserved_zero;
      ar_hs && (ar_idx == IDX_RESERVED) |=> s_axi_rvalid && (s_axi_rdata == 32'h00000000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved word not zero");

endmodule

/* File: testbench/tb_feature_page_regs.sv */
// self-checking bench for the general settings feature page
`timescale 1ns/10ps
module tb_feature_page_regs import feature_page_pkg::*;;
   // clock, reset, enable
   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        ce      = 1'b1;
   // register bus
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   // samples and side controls
   logic [15:0] raw_x = 16'h0123, raw_y = 16'h1234, raw_z = 16'h8000;
   logic [15:0] axis_first, axis_second, axis_third;
   logic        stream_word = 1'b0, host_offset_wr = 1'b0, gain_done = 1'b0;
   logic [7:0]  burst_len;
   logic        burst_end, offset_wr_apply, offset_auto, nvm_prepared;
   logic [10:0] gain_ratio_x, gain_ratio_y, gain_ratio_z;
   logic        gain_ratio_ok, gain_start;
   // bookkeeping
   int          error_cnt   = 0;
   int          check_count = 0;
   int          start_cnt   = 0;
   logic [31:0] rd;
   logic [1:0]  rsp;

   // device under test
   feature_page_regs feature_page_regs_i (
      .ref_clk(ref_clk), .rst(rst), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
      .axis_first(axis_first), .axis_second(axis_second), .axis_third(axis_third),
      .stream_word(stream_word), .burst_len(burst_len), .burst_end(burst_end),
      .host_offset_wr(host_offset_wr), .offset_wr_apply(offset_wr_apply),
      .offset_auto(offset_auto), .nvm_prepared(nvm_prepared),
      .gain_ratio_x(gain_ratio_x), .gain_ratio_y(gain_ratio_y), .gain_ratio_z(gain_ratio_z),
      .gain_ratio_ok(gain_ratio_ok), .gain_start(gain_start), .gain_done(gain_done)
   );

   // free-running clock
   always #5 ref_clk = ~ref_clk;

   // counts gain engine launches
   always @(posedge ref_clk) begin
      if (gain_start === 1'b1) start_cnt++;
   end

   // verdict and end of run
   task automatic close_out();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // compare and report
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one write; address and data offered together, released as each is taken
   task automatic wr(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] r);
      logic aw_go, w_go, aw_done, w_done;
      @(posedge ref_clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'h3;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // own flags, since the valids read here still show the pre-edge values
      aw_done = 1'b0;
      w_done = 1'b0;
      // readies are sampled a half cycle early; inputs only move on rising edges
      while (!(aw_done && w_done)) begin
         @(negedge ref_clk);
         aw_go = !aw_done && (s_axi_awready === 1'b1);
         w_go = !w_done && (s_axi_wready === 1'b1);
         @(posedge ref_clk);
         if (aw_go) s_axi_awvalid <= 1'b0;
         if (w_go) s_axi_wvalid <= 1'b0;
         aw_done = aw_done | aw_go;
         w_done = w_done | w_go;
      end
      while (s_axi_bvalid !== 1'b1) @(negedge ref_clk);
      r = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_bready <= 1'b0;
   endtask

   // one read
   task automatic rdw(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(negedge ref_clk);
      while (s_axi_arready !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(negedge ref_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
   endtask

   // read and compare data and answer code
   task automatic rd_chk(input string nm, input logic [5:0] idx, input logic [31:0] exp,
                         input logic [1:0] er);
      rdw(idx, rd, rsp);
      chk(nm, exp, rd);
      chk("rresp", {30'h0, er}, {30'h0, rsp});
   endtask

   // expected remapped sample for one axis
   function automatic logic [15:0] pick(input logic [1:0] c, input logic [1:0] fb,
                                        input logic s);
      logic [1:0]  e;
      logic [15:0] v;
      e = (c == SRC_RSVD) ? fb : c;
      v = (e == SRC_X) ? raw_x : (e == SRC_Y) ? raw_y : raw_z;
      // the most negative sample has no positive twin, so it saturates
      if (s) v = (v == 16'h8000) ? 16'h7FFF : -v;
      return v;
   endfunction

   // reset values, reserved word and unmapped index
   task automatic t_reset_map();
      rd_chk("rsvd", IDX_RESERVED, 32'h0, RESP_OKAY);
      rd_chk("trig", IDX_TRIG_CFG, 32'h0, RESP_OKAY);
      rd_chk("axis", IDX_GEN_AXIS, {16'h0, RST_GEN_AXIS}, RESP_OKAY);
      rd_chk("gain_z", IDX_GAIN_Z, 32'h0, RESP_OKAY);
      rd_chk("motion", IDX_MOTION, {16'h0, RST_MOTION}, RESP_OKAY);
      chk("first", {16'h0, raw_x}, {16'h0, axis_first});
      chk("second", {16'h0, raw_y}, {16'h0, axis_second});
      chk("third", {16'h0, raw_z}, {16'h0, axis_third});
      wr(IDX_RESERVED, 32'hFFFF_FFFF, rsp);
      rd_chk("rsvd_wr", IDX_RESERVED, 32'h0, RESP_OKAY);
      wr(6'h3F, 32'h0000_FFFF, rsp);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      rd_chk("unmapped", 6'h3F, 32'h0, RESP_SLVERR);
      wr(IDX_GEN_AXIS, 32'hFFFF_FFFF, rsp);
      rd_chk("axis_wide", IDX_GEN_AXIS, 32'h0000_07FF, RESP_OKAY);
   endtask

   // every source code on every axis, signs set except for the reserved code
   task automatic t_remap();
      logic [1:0] c;
      logic       s;
      for (int k = 0; k < 4; k++) begin
         c = k[1:0];
         s = ~&c;
         wr(IDX_GEN_AXIS, {23'h0, s, c, s, c, s, c}, rsp);
         repeat (2) @(posedge ref_clk);
         @(negedge ref_clk);
         chk("first", {16'h0, pick(c, SRC_X, s)}, {16'h0, axis_first});
         chk("second", {16'h0, pick(c, SRC_Y, s)}, {16'h0, axis_second});
         chk("third", {16'h0, pick(c, SRC_Z, s)}, {16'h0, axis_third});
      end
   endtask

   // self offset hand-over and memory preparation
   task automatic t_offset_nvm();
      @(posedge ref_clk);
      host_offset_wr <= 1'b1;
      wr(IDX_GEN_AXIS, 32'h0000_0688, rsp);
      @(negedge ref_clk);
      chk("auto", 32'h1, {31'h0, offset_auto});
      chk("apply", 32'h0, {31'h0, offset_wr_apply});
      chk("nvm", 32'h1, {31'h0, nvm_prepared});
      wr(IDX_GEN_AXIS, {16'h0, RST_GEN_AXIS}, rsp);
      @(negedge ref_clk);
      chk("auto_off", 32'h0, {31'h0, offset_auto});
      chk("apply_on", 32'h1, {31'h0, offset_wr_apply});
      chk("nvm_off", 32'h0, {31'h0, nvm_prepared});
      @(posedge ref_clk);
      host_offset_wr <= 1'b0;
   endtask

   // burst length two: six back-to-back words end three bursts
   task automatic t_burst();
      logic [7:0] ends;
      wr(IDX_TRIG_CFG, 32'hFFFF_FF02, rsp);
      rd_chk("trig_rd", IDX_TRIG_CFG, 32'h0000_0002, RESP_OKAY);
      chk("burst_len", 32'h2, {24'h0, burst_len});
      for (int k = 0; k < 8; k++) begin
         @(posedge ref_clk);
         stream_word <= (k < 6);
         @(negedge ref_clk);
         ends[k] = burst_end;
      end
      chk("burst_end", 32'h54, {24'h0, ends});
   endtask

   // ratio window, launch and self-clearing enable
   task automatic t_gain();
      wr(IDX_GAIN_X, 32'h0000_0300, rsp);
      wr(IDX_GAIN_Y, 32'h0000_0500, rsp);
      wr(IDX_GAIN_Z, 32'h0000_02FF, rsp);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("ratio_x", 32'h300, {21'h0, gain_ratio_x});
      chk("ratio_ok_lo", 32'h0, {31'h0, gain_ratio_ok});
      chk("starts_idle", 32'h0, start_cnt);
      wr(IDX_GAIN_Z, 32'h0000_0C00, rsp);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("ratio_ok", 32'h1, {31'h0, gain_ratio_ok});
      chk("ratio_y", 32'h500, {21'h0, gain_ratio_y});
      chk("ratio_z", 32'h400, {21'h0, gain_ratio_z});
      chk("starts", 32'h1, start_cnt);
      rd_chk("gain_busy", IDX_GAIN_Z, 32'h0000_0C00, RESP_OKAY);
      @(posedge ref_clk);
      gain_done <= 1'b1;
      @(posedge ref_clk);
      gain_done <= 1'b0;
      rd_chk("gain_done", IDX_GAIN_Z, 32'h0000_0400, RESP_OKAY);
      chk("no_restart", 32'h1, start_cnt);
   endtask

   // enable low: words are not counted and the read ready drops
   task automatic t_freeze();
      @(posedge ref_clk);
      ce <= 1'b0;
      stream_word <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("frozen_end", 32'h0, {31'h0, burst_end});
      chk("frozen_rdy", 32'h0, {31'h0, s_axi_arready});
      @(posedge ref_clk);
      ce <= 1'b1;
      stream_word <= 1'b0;
      rd_chk("thaw", IDX_TRIG_CFG, 32'h0000_0002, RESP_OKAY);
      @(posedge ref_clk);
      stream_word <= 1'b1;
      @(posedge ref_clk);
      stream_word <= 1'b0;
      @(negedge ref_clk);
      chk("thaw_end", 32'h0, {31'h0, burst_end});
   endtask

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      close_out();
   end

   // main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      t_reset_map();
      t_remap();
      t_offset_nvm();
      t_burst();
      t_gain();
      t_freeze();
      close_out();
   end
endmodule
